// file: core/cdt_regs.vh
`ifndef CDT_REGS_VH
`define CDT_REGS_VH
// register word indices; byte address is index * 4
`define CDT_IDX_FUNC_LO   5'h00
`define CDT_IDX_FUNC_MID  5'h01
`define CDT_IDX_FUNC_HI   5'h02
`define CDT_IDX_INSEL_LO  5'h03
`define CDT_IDX_INSEL_MID 5'h04
`define CDT_IDX_INSEL_HI  5'h05
`define CDT_IDX_OUT_LO    5'h06
`define CDT_IDX_OUT_MID   5'h07
`define CDT_IDX_OUT_HI    5'h08
`define CDT_IDX_COUNT     5'h09
`define CDT_IDX_PERIOD    5'h0A
`define CDT_IDX_MATCH     5'h0B
`define CDT_IDX_RUN_LO    5'h0C
`define CDT_IDX_RUN_MID   5'h0D
`define CDT_IDX_RUN_HI    5'h0E
// function register fields
`define CDT_FN_CMP_LE     4
`define CDT_FN_IRQ_TC     3
`define CDT_FN_CAP_INV    7
`define CDT_FN_BCAST_EN   6
// output register fields
`define CDT_OUT_TC_EN     2
`define CDT_OUT_ROW_EN    5
// reset values
`define CDT_FUNC_LO_RST   8'h00
`define CDT_FUNC_MID_RST  8'h00
`define CDT_FUNC_HI_RST   8'h20
`define CDT_INSEL_RST     8'h00
`define CDT_INSEL_UP_FIX  4'h3
`define CDT_OUT_RST       8'h00
`define CDT_DATA_RST      24'h000000
`endif

// file: core/cdt_slice.v
`timescale 1ns/1ns
// one 8-bit slice of the chained counter
module cdt_slice (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  input  wire       dec_i,
  input  wire       load_i,
  input  wire [7:0] load_val_i,
  input  wire       zero_in_i,
  input  wire       lt_in_i,
  input  wire       eq_in_i,
  input  wire [7:0] match_i,
  output wire [7:0] count_o,
  output wire       borrow_o,
  output wire       zero_o,
  output wire       lt_o,
  output wire       eq_o
);
  reg [7:0] cnt_ff;
  reg [7:0] nxt_cnt;
  always @* begin
    nxt_cnt = cnt_ff;
    if (load_i)
      nxt_cnt = load_val_i;
    else if (dec_i)
      nxt_cnt = cnt_ff - 8'h01;
  end
  always @(posedge clk_i) begin
    if (rst_i)
      cnt_ff <= 8'h00;
    else if (ce_i)
      cnt_ff <= nxt_cnt;
  end
  assign count_o  = cnt_ff;
  // borrow to the next slice when this byte wraps
  assign borrow_o = dec_i & (cnt_ff == 8'h00);
  assign zero_o   = zero_in_i & (cnt_ff == 8'h00);
  // compare chain: upper slice decides, lower resolves ties
  assign lt_o = (cnt_ff < match_i) | ((cnt_ff == match_i) & lt_in_i);
  assign eq_o = (cnt_ff == match_i) & eq_in_i;
endmodule

// file: core/cdt_sync.v
`timescale 1ns/1ns
// two-flop synchroniser for asynchronous inputs
module cdt_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= {W{1'b0}};
      s2_ff <= {W{1'b0}};
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
    end
  end
  assign q_o = s2_ff;
endmodule

// file: core/cdt_timer.v
`timescale 1ns/1ns
`include "cdt_regs.vh"
module cdt_timer (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output wire        wb_ack_o,
  input  wire [15:0] clk_src_i,
  input  wire [15:0] cap_src_i,
  output wire        tc_o,
  output wire        cmp_o,
  output wire        irq_o,
  output wire        bcast_o,
  output wire [3:0]  row_bus_o,
  output wire [3:0]  out_bus_o,
  output wire [1:0]  clk_sync_o
);
  reg [7:0]  func_ff [0:2];
  reg [7:0]  insel_ff [0:2];
  reg [7:0]  out_ff [0:2];
  reg [23:0] period_ff;
  reg [23:0] match_ff;
  reg        run_ff;
  reg        ack_ff;
  reg [31:0] rdat_ff;
  reg        tc_ff;
  reg        cmp_ff;
  reg        irq_ff;
  reg        bcast_ff;
  reg [3:0]  row_ff;
  reg [3:0]  obus_ff;
  reg [1:0]  csync_ff;
  reg        en_d_ff;
  reg        cap_d_ff;
  reg [31:0] nxt_rdat;
  wire [15:0] clk_s;
  wire [15:0] cap_s;
  wire [23:0] count;
  wire [2:0]  zero_c;
  wire [2:0]  lt_c;
  wire [2:0]  eq_c;
  wire [2:0]  bor_c;
  wire [2:0]  dec_c;
  wire [4:0]  idx = wb_adr_i[6:2];
  wire        req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire        wr = req & wb_we_i;
  wire        wr_per = wr & (idx == `CDT_IDX_PERIOD);
  cdt_sync #(.W(16)) u_clk_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (clk_src_i),
    .q_o   (clk_s)
  );
  cdt_sync #(.W(16)) u_cap_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (cap_src_i),
    .q_o   (cap_s)
  );
  wire en_lvl = clk_s[insel_ff[0][3:0]];
  // selected source is a clock: count on its rising edge
  wire en_act = run_ff & en_lvl & ~en_d_ff;
  wire cap_lvl = cap_s[insel_ff[0][7:4]] ^ func_ff[0][`CDT_FN_CAP_INV];
  wire cap_evt = cap_lvl & ~cap_d_ff;
  wire at_zero = zero_c[2];
  // a step seen at zero is the cycle after terminal count: reload, no wrap
  wire tc_evt = en_act & at_zero;
  wire reload = tc_evt | (wr_per & ~run_ff);
  wire [23:0] load_val = wr_per ? wb_dat_i[23:0] : period_ff;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_slice
      wire zin = (g == 0) ? 1'b1 : zero_c[(g == 0) ? 0 : g - 1];
      wire lin = (g == 0) ? func_ff[2][`CDT_FN_CMP_LE] :
                 lt_c[(g == 0) ? 0 : g - 1];
      wire ein = (g == 0) ? 1'b1 : eq_c[(g == 0) ? 0 : g - 1];
      // decrement passes up on the borrow of the lower slice
      assign dec_c[g] = (g == 0) ? (en_act & ~at_zero) :
                        bor_c[(g == 0) ? 0 : g - 1];
      cdt_slice u_slice (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .dec_i      (dec_c[g]),
        .load_i     (reload),
        .load_val_i (load_val[8*g+7:8*g]),
        .zero_in_i  (zin),
        .lt_in_i    (lin),
        .eq_in_i    (ein),
        .match_i    (match_ff[8*g+7:8*g]),
        .count_o    (count[8*g+7:8*g]),
        .borrow_o   (bor_c[g]),
        .zero_o     (zero_c[g]),
        .lt_o       (lt_c[g]),
        .eq_o       (eq_c[g])
      );
    end
  endgenerate
  // less-equal carried in as the lowest tie-break term
  wire cmp_now = lt_c[2];
  always @* begin
    nxt_rdat = 32'h00000000;
    if (idx == `CDT_IDX_FUNC_LO)
      nxt_rdat[7:0] = func_ff[0];
    else if (idx == `CDT_IDX_FUNC_MID)
      nxt_rdat[7:0] = func_ff[1];
    else if (idx == `CDT_IDX_FUNC_HI)
      nxt_rdat[7:0] = func_ff[2];
    else if (idx == `CDT_IDX_INSEL_LO)
      nxt_rdat[7:0] = insel_ff[0];
    else if (idx == `CDT_IDX_INSEL_MID)
      nxt_rdat[7:0] = insel_ff[1];
    else if (idx == `CDT_IDX_INSEL_HI)
      nxt_rdat[7:0] = insel_ff[2];
    else if (idx == `CDT_IDX_OUT_LO)
      nxt_rdat[7:0] = out_ff[0];
    else if (idx == `CDT_IDX_OUT_MID)
      nxt_rdat[7:0] = out_ff[1];
    else if (idx == `CDT_IDX_OUT_HI)
      nxt_rdat[7:0] = out_ff[2];
    else if (idx == `CDT_IDX_COUNT)
      nxt_rdat[23:0] = count;
    else if (idx == `CDT_IDX_MATCH)
      nxt_rdat[23:0] = match_ff;
    else if (idx == `CDT_IDX_RUN_LO)
      nxt_rdat[0] = run_ff;
  end
  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      func_ff[0]  <= `CDT_FUNC_LO_RST;
      func_ff[1]  <= `CDT_FUNC_MID_RST;
      func_ff[2]  <= `CDT_FUNC_HI_RST;
      for (i = 0; i < 3; i = i + 1) begin
        insel_ff[i] <= (i == 0) ? `CDT_INSEL_RST :
                       {`CDT_INSEL_UP_FIX, 4'h0};
        out_ff[i]   <= `CDT_OUT_RST;
      end
      period_ff <= `CDT_DATA_RST;
      match_ff  <= `CDT_DATA_RST;
      run_ff    <= 1'b0;
      ack_ff    <= 1'b0;
      rdat_ff   <= 32'h00000000;
      en_d_ff   <= 1'b0;
      cap_d_ff  <= 1'b0;
      tc_ff     <= 1'b0;
      cmp_ff    <= 1'b0;
      irq_ff    <= 1'b0;
      bcast_ff  <= 1'b0;
      row_ff    <= 4'h0;
      obus_ff   <= 4'h0;
      csync_ff  <= 2'h0;
    end else if (ce_i) begin
      ack_ff  <= req;
      rdat_ff <= (req & ~wb_we_i) ? nxt_rdat : 32'h00000000;
      if (wr & wb_sel_i[0]) begin
        if (idx == `CDT_IDX_FUNC_LO)
          func_ff[0] <= {wb_dat_i[7:6], 1'b0, wb_dat_i[4], 4'h0};
        else if (idx == `CDT_IDX_FUNC_MID)
          func_ff[1] <= {3'h0, wb_dat_i[4], 4'h0};
        else if (idx == `CDT_IDX_FUNC_HI)
          func_ff[2] <= {3'h1, wb_dat_i[4:3], 3'h0};
        else if (idx == `CDT_IDX_INSEL_LO)
          insel_ff[0] <= wb_dat_i[7:0];
        else if (idx == `CDT_IDX_INSEL_MID)
          insel_ff[1] <= {`CDT_INSEL_UP_FIX, wb_dat_i[3:0]};
        else if (idx == `CDT_IDX_INSEL_HI)
          insel_ff[2] <= {`CDT_INSEL_UP_FIX, wb_dat_i[3:0]};
        else if (idx == `CDT_IDX_OUT_LO)
          out_ff[0] <= {wb_dat_i[7:6], 6'h00};
        else if (idx == `CDT_IDX_OUT_MID)
          out_ff[1] <= {wb_dat_i[7:6], 6'h00};
        else if (idx == `CDT_IDX_OUT_HI)
          out_ff[2] <= wb_dat_i[7:0];
        else if (idx == `CDT_IDX_RUN_LO)
          run_ff <= wb_dat_i[0];
      end
      if (wr_per)
        period_ff <= wb_dat_i[23:0];
      // capture wins over a software write of the same cycle
      if (cap_evt)
        match_ff <= count;
      else if (wr & (idx == `CDT_IDX_MATCH))
        match_ff <= wb_dat_i[23:0];
      en_d_ff   <= en_lvl;
      cap_d_ff  <= cap_lvl;
      tc_ff    <= tc_evt;
      cmp_ff   <= cmp_now;
      irq_ff   <= func_ff[2][`CDT_FN_IRQ_TC] ? tc_evt : cmp_now;
      bcast_ff <= func_ff[0][`CDT_FN_BCAST_EN] & tc_evt;
      row_ff   <= {3'h0, out_ff[2][`CDT_OUT_ROW_EN] & cmp_now}
                  << out_ff[2][4:3];
      obus_ff  <= {3'h0, out_ff[2][`CDT_OUT_TC_EN] & tc_evt}
                  << out_ff[2][1:0];
      csync_ff <= out_ff[2][7:6];
    end
  end
  assign wb_ack_o   = ack_ff;
  assign wb_dat_o   = rdat_ff;
  assign tc_o       = tc_ff;
  assign cmp_o      = cmp_ff;
  assign irq_o      = irq_ff;
  assign bcast_o    = bcast_ff;
  assign row_bus_o  = row_ff;
  assign out_bus_o  = obus_ff;
  assign clk_sync_o = csync_ff;
endmodule

// file: test/cdt_timer_sva.sv
`timescale 1ns/1ns
module cdt_timer_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        tc_o,
  input wire logic        cmp_o,
  input wire logic        irq_o,
  input wire logic        bcast_o,
  input wire logic [3:0]  row_bus_o,
  input wire logic [3:0]  out_bus_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property (
    wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without a strobe");
  a_rdata_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_tc_single_pulse: assert property (tc_o |=> !tc_o)
    else $error("terminal count pulse too long");
  a_bcast_single_pulse: assert property (bcast_o |=> !bcast_o)
    else $error("broadcast pulse too long");
  a_outbus_one_hot: assert property ($onehot0(out_bus_o))
    else $error("more than one output bus driven");
  a_rowbus_one_hot: assert property ($onehot0(row_bus_o))
    else $error("more than one row bus driven");
  // reset itself is the antecedent here, so no disable
  a_reset_quiet_outs: assert property (disable iff (1'b0)
    rst_i |=> !tc_o && !cmp_o && !irq_o && out_bus_o == 4'h0)
    else $error("outputs active during reset");

  c_tc_seen: cover property (tc_o);
  c_bcast_seen: cover property (bcast_o);
  c_cmp_seen: cover property (cmp_o && irq_o);
endmodule

// file: test/cdt_src_model.sv
`timescale 1ns/1ns
// clock/enable and capture sources; only source 0 of each is exercised
module cdt_src_model (
  input  wire logic        clk_i,
  output logic      [15:0] clk_src_o,
  output logic      [15:0] cap_src_o
);
  initial begin
    clk_src_o = 16'h0000;
    cap_src_o = 16'h0000;
  end
  // slow pulses so the two-flop synchroniser never misses an edge
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_i);
      clk_src_o[0] <= 1'b1;
      repeat (4) @(posedge clk_i);
      clk_src_o[0] <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  task automatic cap(input logic v);
    @(posedge clk_i);
    cap_src_o[0] <= v;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ns
`include "cdt_regs.vh"
module tb_top;
  logic        clk_i, rst_i, cyc, stb, we, ce;
  logic [3:0]  sel, ob_or;
  logic [31:0] adr, wdat, q;
  wire  [31:0] rdat;
  wire         ack, tc, cmp, irq, bc;
  wire  [3:0]  row_bus, out_bus;
  wire  [1:0]  clk_sync;
  wire  [15:0] clk_src, cap_src;
  int          fail_count, checks, n_tc, n_bc;

  cdt_src_model src_inst (.clk_i(clk_i), .clk_src_o(clk_src),
    .cap_src_o(cap_src));
  cdt_timer cdt_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we),
    .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .clk_src_i(clk_src), .cap_src_i(cap_src), .tc_o(tc), .cmp_o(cmp),
    .irq_o(irq), .bcast_o(bc), .row_bus_o(row_bus), .out_bus_o(out_bus),
    .clk_sync_o(clk_sync));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // one-cycle pulses are counted so a later check cannot miss them
  always @(posedge clk_i) begin
    if (rst_i) begin
      n_tc <= 0;
      n_bc <= 0;
      ob_or <= 4'h0;
    end else begin
      if (tc)
        n_tc <= n_tc + 1;
      if (bc)
        n_bc <= n_bc + 1;
      ob_or <= ob_or | out_bus;
    end
  end

  task automatic chk(input [31:0] g, input [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wb(input [4:0] idx, input w, input [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= {25'h0, idx, 2'h0};
    wdat <= d;
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    q = rdat;
    chk({31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input [4:0] idx, input [31:0] e);
    wb(idx, 1'b0, 32'h0);
    chk(q, e);
  endtask

  task automatic final_report;
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    final_report;
  end

  initial begin
    {rst_i, cyc, stb, we, adr, wdat} = {1'b1, 3'h0, 64'h0};
    ce = 1'b1;
    sel = 4'hF;
    fail_count = 0;
    checks = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`CDT_IDX_FUNC_HI, 32'h20);
    rd(`CDT_IDX_INSEL_MID, 32'h30);
    sel <= 4'hE;
    wb(`CDT_IDX_INSEL_HI, 1'b1, 32'hC5);
    sel <= 4'hF;
    rd(`CDT_IDX_INSEL_HI, 32'h30);
    wb(`CDT_IDX_INSEL_HI, 1'b1, 32'hC5);
    rd(`CDT_IDX_INSEL_HI, 32'h35);
    wb(`CDT_IDX_OUT_LO, 1'b1, 32'hFF);
    rd(`CDT_IDX_OUT_LO, 32'hC0);
    wb(`CDT_IDX_RUN_MID, 1'b1, 32'hFF);
    rd(`CDT_IDX_RUN_MID, 32'h0);
    wb(`CDT_IDX_PERIOD, 1'b1, 32'h3);
    rd(`CDT_IDX_PERIOD, 32'h0);
    rd(`CDT_IDX_COUNT, 32'h3);
    rd(5'h1F, 32'h0);
    // stopped count of 3 against match 3: only less-or-equal holds
    wb(`CDT_IDX_MATCH, 1'b1, 32'h3);
    wb(`CDT_IDX_FUNC_HI, 1'b1, 32'h30);
    wb(`CDT_IDX_OUT_HI, 1'b1, 32'hF6);
    repeat (4) @(posedge clk_i);
    chk({31'h0, cmp}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    chk({28'h0, row_bus}, 32'h4);
    chk({30'h0, clk_sync}, 32'h3);
    wb(`CDT_IDX_FUNC_HI, 1'b1, 32'h28);
    repeat (4) @(posedge clk_i);
    chk({31'h0, cmp}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk({28'h0, row_bus}, 32'h0);
    wb(`CDT_IDX_FUNC_LO, 1'b1, 32'h40);
    rd(`CDT_IDX_OUT_HI, 32'hF6);
    wb(`CDT_IDX_RUN_LO, 1'b1, 32'h1);
    src_inst.step(1);
    rd(`CDT_IDX_COUNT, 32'h2);
    // enable low freezes the count even across a source edge
    ce <= 1'b0;
    src_inst.step(1);
    ce <= 1'b1;
    rd(`CDT_IDX_COUNT, 32'h2);
    wb(`CDT_IDX_INSEL_LO, 1'b1, 32'h01);
    src_inst.step(1);
    rd(`CDT_IDX_COUNT, 32'h2);
    wb(`CDT_IDX_INSEL_LO, 1'b1, 32'h00);
    src_inst.step(2);
    rd(`CDT_IDX_COUNT, 32'h0);
    chk(n_tc, 32'h0);
    src_inst.step(1);
    rd(`CDT_IDX_COUNT, 32'h3);
    chk(n_tc, 32'h1);
    chk(n_bc, 32'h1);
    chk({28'h0, ob_or}, 32'h4);
    wb(`CDT_IDX_RUN_LO, 1'b1, 32'h0);
    src_inst.step(1);
    rd(`CDT_IDX_COUNT, 32'h3);
    chk(n_tc, 32'h1);
    src_inst.cap(1'b1);
    rd(`CDT_IDX_MATCH, 32'h3);
    // inverting while the input is high is a falling edge: no capture
    wb(`CDT_IDX_MATCH, 1'b1, 32'h0);
    wb(`CDT_IDX_FUNC_LO, 1'b1, 32'hC0);
    rd(`CDT_IDX_MATCH, 32'h0);
    src_inst.cap(1'b0);
    rd(`CDT_IDX_MATCH, 32'h3);
    // borrow must ripple through both upper slices
    wb(`CDT_IDX_PERIOD, 1'b1, 32'h010000);
    wb(`CDT_IDX_RUN_LO, 1'b1, 32'h1);
    src_inst.step(1);
    rd(`CDT_IDX_COUNT, 32'h00FFFF);
    final_report;
  end
endmodule

bind cdt_timer cdt_timer_sva cdt_timer_sva_inst (.clk_i(clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .tc_o(tc_o), .cmp_o(cmp_o),
  .irq_o(irq_o), .bcast_o(bcast_o), .row_bus_o(row_bus_o),
  .out_bus_o(out_bus_o));
